// ---- shared/tas_pkg.sv ----
// Constants and types for the application-select register bank and its measurement engine.
// Assumes a single 125 MHz system clock shared by every module that imports these names.
package tas_pkg;
	// Register offsets
	localparam logic [7:0] REG_RUNNING_APP = 8'h00;
	localparam logic [7:0] REG_MAJOR_REV = 8'h01;
	localparam logic [7:0] REG_REQ_APP = 8'h02;
	// Reset values and application codes
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] APP_BOOT = 8'h80;
	localparam logic [7:0] APP_MEAS = 8'hc0;
	// Revisions loaded when an application starts; values are arbitrary
	localparam logic [7:0] BOOT_MAJOR_REV = 8'h01;
	localparam logic [7:0] MEAS_MAJOR_REV = 8'h02;
	// Measurement commands and default-mode parameters
	localparam logic [7:0] CMD_MEAS_A = 8'h02;
	localparam logic [7:0] CMD_MEAS_B = 8'h03;
	localparam logic [7:0] DEF_PARAM6 = 8'ha3;
	localparam logic [7:0] DEF_PARAM3 = 8'h00;
	localparam logic [7:0] DEF_PARAM1 = 8'h03;
	localparam logic [7:0] DEF_PARAM0 = 8'h84;
	localparam logic [15:0] DEF_ITER_K = 16'h0384;
	localparam logic [7:0] DEF_THRESHOLD = 8'h00;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MEAS_TIME_MS = 33;
	localparam int MEAS_CYCLES = MEAS_TIME_MS * CLK_MHZ * 1000;
	localparam int ITER_K_CYCLES = MEAS_CYCLES / 900;
	localparam int EMIT_PERIOD_NS = 23;
	localparam int APP_START_CYCLES = 16;
	// Distances in millimetres, one step per mm
	localparam logic [15:0] LONG_MODE_MM = 16'h00c8;
	localparam logic [15:0] NO_OBJECT_LIMIT_MM = 16'h09c4;
	localparam logic [15:0] NO_OBJECT_MM = 16'hffff;
	// State types
	typedef enum logic [0:0] {
		APP_RUN = 1'b0,
		APP_LOAD = 1'b1
	} tas_app_state_t;
	typedef enum logic [0:0] {
		MS_IDLE = 1'b0,
		MS_RUN = 1'b1
	} tas_meas_state_t;
endpackage : tas_pkg

// ---- shared/tas_meas_if.sv ----
// Carrier between the register bank and the measurement engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface tas_meas_if;
	logic start;
	logic [15:0] iter_k;
	logic [7:0] threshold;
	logic halve;
	logic sample_valid;
	logic [15:0] sample_mm;
	logic [7:0] sample_strength;
	logic busy;
	logic done;
	logic [15:0] result_mm;
	logic long_mode;
	logic emit_pulse;
	modport ctrl (output start, iter_k, threshold, halve, sample_valid, sample_mm, sample_strength,
		input busy, done, result_mm, long_mode, emit_pulse);
	modport meas (input start, iter_k, threshold, halve, sample_valid, sample_mm, sample_strength,
		output busy, done, result_mm, long_mode, emit_pulse);
endinterface : tas_meas_if

// ---- src/tas_measure.sv ----
// Measurement engine: iteration timing, emitter pulse pacing, closest-object search, range mode.
// Assumes start arrives only while idle and that samples come from logic on the same clock.
`timescale 1ns/100ps
module tas_measure #(
	parameter int ITER_K_CYCLES = tas_pkg::ITER_K_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Engine side of the carrier
	tas_meas_if.meas mif
);
	tas_pkg::tas_meas_state_t state_reg, state_next;
	logic [31:0] tick_reg, tick_next;
	logic [15:0] left_reg, left_next;
	logic [15:0] best_reg, best_next;
	logic [15:0] result_reg, result_next;
	logic long_reg, long_next;
	logic done_reg, done_next;
	logic [7:0] acc_reg, acc_next;
	logic pulse_reg, pulse_next;
	logic [7:0] period;

	always_comb begin
		state_next = state_reg;
		tick_next = tick_reg;
		left_next = left_reg;
		best_next = best_reg;
		result_next = result_reg;
		long_next = long_reg;
		done_next = 1'b0;
		pulse_next = 1'b0;
		acc_next = acc_reg + 8'(tas_pkg::CLK_PERIOD_NS);
		// Halving doubles the period rather than skipping pulses
		period = mif.halve ? 8'(2 * tas_pkg::EMIT_PERIOD_NS) : 8'(tas_pkg::EMIT_PERIOD_NS);
		case (state_reg)
			tas_pkg::MS_IDLE: begin
				acc_next = 8'h00;
				if (mif.start) begin
					state_next = tas_pkg::MS_RUN;
					tick_next = 32'h0;
					left_next = mif.iter_k;
					best_next = tas_pkg::NO_OBJECT_MM;
				end
			end
			tas_pkg::MS_RUN: begin
				// Phase accumulator keeps the 23 ns average (46 ns when halved) on an 8 ns clock
				if (acc_next >= period) begin
					acc_next = acc_next - period;
					pulse_next = 1'b1;
				end
				// Closest object wins, 1 mm per step
				if (mif.sample_valid && mif.sample_strength > mif.threshold && mif.sample_mm < best_reg) begin
					best_next = mif.sample_mm;
				end
				if (left_reg == 16'h0000) begin
					state_next = tas_pkg::MS_IDLE;
					done_next = 1'b1;
					// No shot in the result cycle, the emitter fires only while busy
					pulse_next = 1'b0;
					result_next = best_reg;
					// Long range at or above the switch point, with the reduced array
					long_next = (best_reg >= tas_pkg::LONG_MODE_MM);
				end else if (tick_reg == 32'(ITER_K_CYCLES - 1)) begin
					// One thousand iterations per tick span
					tick_next = 32'h0;
					left_next = left_reg - 16'h0001;
				end else begin
					tick_next = tick_reg + 32'h1;
				end
			end
			default: begin
				state_next = tas_pkg::MS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= tas_pkg::MS_IDLE;
			tick_reg <= 32'h0;
			left_reg <= 16'h0000;
			best_reg <= tas_pkg::NO_OBJECT_MM;
			result_reg <= tas_pkg::NO_OBJECT_MM;
			long_reg <= 1'b0;
			done_reg <= 1'b0;
			acc_reg <= 8'h00;
			pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tick_reg <= tick_next;
			left_reg <= left_next;
			best_reg <= best_next;
			result_reg <= result_next;
			long_reg <= long_next;
			done_reg <= done_next;
			acc_reg <= acc_next;
			pulse_reg <= pulse_next;
		end
	end

	assign mif.busy = (state_reg == tas_pkg::MS_RUN);
	assign mif.done = done_reg;
	assign mif.result_mm = result_reg;
	assign mif.long_mode = long_reg;
	assign mif.emit_pulse = pulse_reg;

	// Helper: cycles spent running and the iteration count of the current run
	logic [47:0] run_cnt;
	logic [15:0] run_iter;
	always_ff @(posedge clk) begin
		if (srst) begin
			run_cnt <= 48'h0;
			run_iter <= 16'h0000;
		end else if (state_reg == tas_pkg::MS_IDLE && mif.start) begin
			run_cnt <= 48'h0;
			run_iter <= mif.iter_k;
		end else if (state_reg == tas_pkg::MS_RUN) begin
			run_cnt <= run_cnt + 48'h1;
		end
	end

	chk_meas_length: assert property (@(posedge clk) disable iff (srst)
		done_reg |-> run_cnt == 48'(run_iter) * 48'(ITER_K_CYCLES) + 48'h1)
		else $error("measurement length does not match iteration count");
	chk_closest_kept: assert property (@(posedge clk) disable iff (srst)
		state_reg == tas_pkg::MS_RUN && mif.sample_valid && mif.sample_strength > mif.threshold
		&& mif.sample_mm < best_reg |=> best_reg == $past(mif.sample_mm))
		else $error("closer sample not kept");
	chk_range_mode: assert property (@(posedge clk) disable iff (srst)
		done_reg |-> long_reg == (result_reg >= tas_pkg::LONG_MODE_MM))
		else $error("range mode does not follow reported distance");
	chk_emit_spacing: assert property (@(posedge clk) disable iff (srst)
		pulse_reg |=> !pulse_reg)
		else $error("emitter pulses closer than 23 ns");
	chk_emit_halved: assert property (@(posedge clk) disable iff (srst)
		pulse_reg && mif.halve |=> (!pulse_reg || !mif.halve)[*4])
		else $error("halved emitter pulses too close");
	cov_no_object: cover property (@(posedge clk) disable iff (srst)
		done_reg && result_reg > tas_pkg::NO_OBJECT_LIMIT_MM);
	cov_long_range: cover property (@(posedge clk) disable iff (srst) done_reg && long_reg);
endmodule : tas_measure

// ---- src/tas_app_select_regs.sv ----
// Application-select register bank with measurement command decode for a distance sensor.
// Assumes the register port and command port are driven by the interface front end on CLK_SYS;
// the clock-halving strap and nothing else arrives from outside the clock domain.
// Operation
// - Default mode runs 900 k iterations, threshold zero, about 33 ms each.
// - Closest object distance is reported in 1 mm steps.
// - Switch to long range near 200 mm, using a reduced detector array.
// - Emitter pulses every 23 ns; halving setting doubles that period.
// - Running-application register reads 0xC0 for measurement, 0x80 for bootloader.
// - Writing 0x80 or 0xC0 to the request register while no application is loading starts that application.
`timescale 1ns/100ps
module tas_app_select_regs #(
	parameter int ITER_K_CYCLES = tas_pkg::ITER_K_CYCLES,
	parameter int APP_START_CYCLES = tas_pkg::APP_START_CYCLES
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WE,
	input wire logic REG_RE,
	output logic [7:0] REG_RDATA,
	// Measurement command port
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_CODE,
	input wire logic [7:0] CMD_PARAM0,
	input wire logic [7:0] CMD_PARAM1,
	input wire logic [7:0] CMD_PARAM3,
	input wire logic [7:0] CMD_PARAM6,
	output logic CMD_ACCEPT,
	// Emitter clock-halving strap, asynchronous
	input wire logic EMIT_CLK_HALVE,
	// Detector samples
	input wire logic SAMPLE_VALID,
	input wire logic [15:0] SAMPLE_MM,
	input wire logic [7:0] SAMPLE_STRENGTH,
	// Measurement results
	output logic MEAS_BUSY,
	output logic RESULT_VALID,
	output logic [15:0] RESULT_MM,
	output logic LONG_MODE,
	output logic DEFAULT_MODE,
	output logic EMIT_PULSE
);
	tas_meas_if mif ();

	tas_pkg::tas_app_state_t app_state_reg, app_state_next;
	logic [7:0] running_reg, running_next;
	logic [7:0] rev_reg, rev_next;
	logic [7:0] req_reg, req_next;
	logic [7:0] target_reg, target_next;
	logic [15:0] start_cnt_reg, start_cnt_next;
	logic [7:0] rdata_reg, rdata_next;
	logic halve_meta_reg, halve_sync_reg;
	logic start_reg, start_next;
	logic [15:0] iter_reg, iter_next;
	logic [7:0] thresh_reg, thresh_next;
	logic default_reg, default_next;
	logic req_write, req_valid, cmd_is_meas, cmd_is_default;

	assign req_write = REG_WE && REG_ADDR == tas_pkg::REG_REQ_APP;
	assign req_valid = REG_WDATA == tas_pkg::APP_BOOT || REG_WDATA == tas_pkg::APP_MEAS;
	assign cmd_is_meas = CMD_CODE == tas_pkg::CMD_MEAS_A || CMD_CODE == tas_pkg::CMD_MEAS_B;
	// Default mode only when all four parameters match
	assign cmd_is_default = CMD_PARAM6 == tas_pkg::DEF_PARAM6 && CMD_PARAM3 == tas_pkg::DEF_PARAM3
		&& CMD_PARAM1 == tas_pkg::DEF_PARAM1 && CMD_PARAM0 == tas_pkg::DEF_PARAM0;
	// Commands are refused while an application is loading, relying on the host poll
	assign CMD_ACCEPT = CMD_VALID && cmd_is_meas && running_reg == tas_pkg::APP_MEAS
		&& app_state_reg == tas_pkg::APP_RUN && !mif.busy && !start_reg;

	// Application select and register file
	always_comb begin
		app_state_next = app_state_reg;
		running_next = running_reg;
		rev_next = rev_reg;
		req_next = req_reg;
		target_next = target_reg;
		start_cnt_next = start_cnt_reg;
		rdata_next = rdata_reg;
		if (REG_WE && REG_ADDR == tas_pkg::REG_MAJOR_REV) begin
			rev_next = REG_WDATA;
		end
		case (app_state_reg)
			tas_pkg::APP_RUN: begin
				// Only the two known codes launch anything
				if (req_write && req_valid) begin
					app_state_next = tas_pkg::APP_LOAD;
					target_next = REG_WDATA;
					start_cnt_next = 16'h0000;
				end
			end
			tas_pkg::APP_LOAD: begin
				if (start_cnt_reg == 16'(APP_START_CYCLES - 1)) begin
					// Status shows the started application
					app_state_next = tas_pkg::APP_RUN;
					running_next = target_reg;
					rev_next = (target_reg == tas_pkg::APP_MEAS) ? tas_pkg::MEAS_MAJOR_REV : tas_pkg::BOOT_MAJOR_REV;
				end else begin
					start_cnt_next = start_cnt_reg + 16'h0001;
				end
			end
			default: begin
				app_state_next = tas_pkg::APP_RUN;
			end
		endcase
		// Request register keeps whatever was written; a later load retargets nothing mid-flight
		if (req_write) begin
			req_next = REG_WDATA;
		end
		if (REG_RE) begin
			case (REG_ADDR)
				tas_pkg::REG_RUNNING_APP: rdata_next = running_reg;
				tas_pkg::REG_MAJOR_REV: rdata_next = rev_reg;
				tas_pkg::REG_REQ_APP: rdata_next = req_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			app_state_reg <= tas_pkg::APP_RUN;
			running_reg <= tas_pkg::REG_RESET_VAL;
			rev_reg <= tas_pkg::REG_RESET_VAL;
			req_reg <= tas_pkg::REG_RESET_VAL;
			target_reg <= tas_pkg::REG_RESET_VAL;
			start_cnt_reg <= 16'h0000;
			rdata_reg <= 8'h00;
		end else begin
			app_state_reg <= app_state_next;
			running_reg <= running_next;
			rev_reg <= rev_next;
			req_reg <= req_next;
			target_reg <= target_next;
			start_cnt_reg <= start_cnt_next;
			rdata_reg <= rdata_next;
		end
	end

	// Command decode into the measurement engine
	always_comb begin
		start_next = 1'b0;
		iter_next = iter_reg;
		thresh_next = thresh_reg;
		default_next = default_reg;
		if (CMD_ACCEPT) begin
			// Parameters 1:0 give thousands of iterations, parameter 3 the threshold
			start_next = 1'b1;
			iter_next = {CMD_PARAM1, CMD_PARAM0};
			thresh_next = CMD_PARAM3;
			default_next = cmd_is_default;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			start_reg <= 1'b0;
			iter_reg <= tas_pkg::DEF_ITER_K;
			thresh_reg <= tas_pkg::DEF_THRESHOLD;
			default_reg <= 1'b0;
			halve_meta_reg <= 1'b0;
			halve_sync_reg <= 1'b0;
		end else begin
			start_reg <= start_next;
			iter_reg <= iter_next;
			thresh_reg <= thresh_next;
			default_reg <= default_next;
			halve_meta_reg <= EMIT_CLK_HALVE;
			halve_sync_reg <= halve_meta_reg;
		end
	end

	assign mif.start = start_reg;
	assign mif.iter_k = iter_reg;
	assign mif.threshold = thresh_reg;
	assign mif.halve = halve_sync_reg;
	assign mif.sample_valid = SAMPLE_VALID;
	assign mif.sample_mm = SAMPLE_MM;
	assign mif.sample_strength = SAMPLE_STRENGTH;

	tas_measure #(
		.ITER_K_CYCLES(ITER_K_CYCLES)
	) u_measure (
		.clk(CLK_SYS),
		.srst(SRST),
		.mif(mif)
	);

	assign REG_RDATA = rdata_reg;
	assign MEAS_BUSY = mif.busy;
	assign RESULT_VALID = mif.done;
	assign RESULT_MM = mif.result_mm;
	assign LONG_MODE = mif.long_mode;
	assign DEFAULT_MODE = default_reg;
	assign EMIT_PULSE = mif.emit_pulse;

	chk_meas_app_up: assert property (@(posedge CLK_SYS) disable iff (SRST)
		app_state_reg == tas_pkg::APP_RUN && req_write && REG_WDATA == tas_pkg::APP_MEAS
		|-> ##(APP_START_CYCLES + 1) running_reg == tas_pkg::APP_MEAS)
		else $error("measurement application did not start");
	chk_boot_app_up: assert property (@(posedge CLK_SYS) disable iff (SRST)
		app_state_reg == tas_pkg::APP_RUN && req_write && REG_WDATA == tas_pkg::APP_BOOT
		|-> ##(APP_START_CYCLES + 1) running_reg == tas_pkg::APP_BOOT)
		else $error("bootloader did not start");
	chk_status_read: assert property (@(posedge CLK_SYS) disable iff (SRST)
		REG_RE && REG_ADDR == tas_pkg::REG_RUNNING_APP |=> REG_RDATA == $past(running_reg))
		else $error("status read does not show running application");
	chk_status_codes: assert property (@(posedge CLK_SYS) disable iff (SRST)
		$changed(running_reg) |-> running_reg == tas_pkg::APP_MEAS || running_reg == tas_pkg::APP_BOOT)
		else $error("running application shows an undefined code");
	chk_bad_req_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
		app_state_reg == tas_pkg::APP_RUN && req_write && !req_valid
		|=> app_state_reg == tas_pkg::APP_RUN && $stable(running_reg))
		else $error("unknown request code disturbed the running application");
	chk_default_setup: assert property (@(posedge CLK_SYS) disable iff (SRST)
		CMD_ACCEPT && cmd_is_default
		|=> iter_reg == tas_pkg::DEF_ITER_K && thresh_reg == tas_pkg::DEF_THRESHOLD && default_reg)
		else $error("default mode not set to 900 k iterations and zero threshold");
	cov_default_meas: cover property (@(posedge CLK_SYS) disable iff (SRST)
		CMD_ACCEPT && cmd_is_default ##1 MEAS_BUSY);
	cov_boot_switch: cover property (@(posedge CLK_SYS) disable iff (SRST)
		running_reg == tas_pkg::APP_MEAS ##1 running_reg == tas_pkg::APP_BOOT);
endmodule : tas_app_select_regs

// ---- verif/tas_host_model.sv ----
// Host model: the processor that writes, reads and issues measurement commands.
// Assumes the bench calls its tasks one at a time; lines change only at falling edges.
`timescale 1ns/100ps
module tas_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata,
	// Command port
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [31:0] cmd_params,
	input wire logic cmd_accept
);
	initial begin
		{reg_addr, reg_wdata, reg_we, reg_re, cmd_valid, cmd_code, cmd_params} = '0;
	end
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge clk);
		reg_we = 1'b0;
		// Released lines must not keep looking valid
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_re = 1'b1;
		@(negedge clk);
		reg_re = 1'b0;
		d = reg_rdata;
		reg_addr = ~a;
	endtask : reg_read
	// Bounded wait: a slow start shows as a wrong value, not a hang
	task automatic poll_app(input logic [7:0] want, output logic [7:0] d);
		for (int i = 0; i < 10; i++) begin
			reg_read(8'h00, d);
			if (d === want) break;
		end
	endtask : poll_app
	// Params packed as {p6, p3, p1, p0}
	task automatic command(input logic [7:0] code, input logic [31:0] p, output logic acc);
		acc = 1'b0;
		@(negedge clk);
		cmd_code = code;
		cmd_params = p;
		cmd_valid = 1'b1;
		for (int i = 0; i < 6 && !acc; i++) begin
			#1;
			if (cmd_accept === 1'b1) begin
				acc = 1'b1;
				@(posedge clk);
			end
			@(negedge clk);
		end
		cmd_valid = 1'b0;
		cmd_code = ~code;
		cmd_params = ~p;
	endtask : command
endmodule : tas_host_model

// ---- verif/tb.sv ----
// Testbench for the application-select register bank and measurement engine.
// Assumes shortened counts: four cycles per thousand iterations, three cycles per start.
`timescale 1ns/100ps
module tb;
	localparam int IKC = 4;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic emit_halve = 1'b0;
	logic sample_valid = 1'b0;
	logic [15:0] sample_mm = '0;
	logic [7:0] sample_str = '0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_code;
	logic reg_we, reg_re, cmd_valid, cmd_accept;
	logic [31:0] cmd_params;
	logic meas_busy, result_valid, long_mode, default_mode, emit_pulse;
	logic [15:0] result_mm;
	logic [31:0] seed = 32'h7780;
	int num_errors = 0;
	int n_tests = 0;
	always #4 clk_sys = ~clk_sys;
	tas_host_model host (.clk(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_params(cmd_params), .cmd_accept(cmd_accept));
	tas_app_select_regs #(.ITER_K_CYCLES(IKC), .APP_START_CYCLES(3)) DUT (.CLK_SYS(clk_sys), .SRST(srst),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata),
		.CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_PARAM0(cmd_params[7:0]),
		.CMD_PARAM1(cmd_params[15:8]), .CMD_PARAM3(cmd_params[23:16]), .CMD_PARAM6(cmd_params[31:24]),
		.CMD_ACCEPT(cmd_accept), .EMIT_CLK_HALVE(emit_halve), .SAMPLE_VALID(sample_valid),
		.SAMPLE_MM(sample_mm), .SAMPLE_STRENGTH(sample_str), .MEAS_BUSY(meas_busy),
		.RESULT_VALID(result_valid), .RESULT_MM(result_mm), .LONG_MODE(long_mode),
		.DEFAULT_MODE(default_mode), .EMIT_PULSE(emit_pulse));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Only the two defined codes move the running application
	function automatic logic [7:0] exp_app(input logic [7:0] code, input logic [7:0] prev);
		return (code == 8'h80 || code == 8'hc0) ? code : prev;
	endfunction : exp_app
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_val(what, {15'h0, exp}, {15'h0, got});
	endtask : chk_bit
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	// fix_mm of zero means random samples; otherwise every sample is that distance at full strength
	task automatic run_meas(input logic [7:0] code, input logic [15:0] n, input logic [7:0] thr,
		input logic [7:0] p6, input int nsamp, input logic halve, input logic [15:0] fix_mm);
		logic acc;
		logic [15:0] best;
		logic [31:0] r;
		int cyc, sent, pulses, stray, expp;
		best = 16'hffff;
		{cyc, sent, pulses, stray} = {32'd1, 32'd0, 32'd0, 32'd0};
		emit_halve = halve;
		repeat (4) @(negedge clk_sys);
		host.command(code, {p6, thr, n}, acc);
		chk_bit("command taken", 1'b1, acc);
		chk_bit("default flag", n == 16'h0384 && thr == 8'h00 && p6 == tas_pkg::DEF_PARAM6, default_mode);
		while (result_valid !== 1'b1 && cyc < 4000) begin
			@(negedge clk_sys);
			cyc++;
			if (emit_pulse === 1'b1) begin
				if (meas_busy === 1'b1) pulses++;
				else stray++;
			end
			if (meas_busy === 1'b1 && sent < nsamp) begin
				r = rnd();
				sample_mm = (fix_mm != 0) ? fix_mm : {4'h0, r[11:0]};
				sample_str = (fix_mm != 0) ? 8'hff : r[23:16];
				sample_valid = 1'b1;
				sent++;
				if (sample_str > thr && sample_mm < best) best = sample_mm;
			end else begin
				sample_valid = 1'b0;
				sample_mm = ~sample_mm;
			end
		end
		chk_val("result delay", 16'(3 + n * IKC), 16'(cyc));
		chk_bit("busy after result", 1'b0, meas_busy);
		chk_val("result mm", best, result_mm);
		chk_bit("long mode", best >= tas_pkg::LONG_MODE_MM, long_mode);
		// Phase accumulator may carry one pulse of slack either way
		expp = (n * IKC + 1) * tas_pkg::CLK_PERIOD_NS / (tas_pkg::EMIT_PERIOD_NS * (halve ? 2 : 1));
		chk_val("emitter pulses", 16'(expp), 16'((pulses >= expp - 1 && pulses <= expp + 1) ? expp : pulses));
		chk_val("stray pulses", 16'h0, 16'(stray));
		@(negedge clk_sys);
		chk_bit("result pulse", 1'b0, result_valid);
		$display("Test measurement code %h length %0d done", code, n);
	endtask : run_meas
	// Longest test is about 3.6k cycles; all tests stay under 6k, so 20k cycles means a hang
	initial begin
		#160000;
		num_errors++;
		finish_test();
	end
	initial begin
		logic [7:0] d, code, app, rev;
		logic acc;
		repeat (3) @(negedge clk_sys);
		srst = 1'b0;
		chk_val("result after reset", 16'hffff, result_mm);
		// Offsets 0x00 to 0x02 and one unmapped offset
		for (int a = 0; a < 4; a++) begin
			host.reg_read(8'(a), d);
			chk_val("register reset", {8'h0, tas_pkg::REG_RESET_VAL}, {8'h0, d});
		end
		host.command(tas_pkg::CMD_MEAS_A, 32'ha3000384, acc);
		chk_bit("command with no app", 1'b0, acc);
		$display("Test reset done");
		{app, rev} = 16'h0;
		for (int i = 0; i < 7; i++) begin
			code = (i % 2 == 1) ? 8'(rnd()) : ((i % 4 == 0) ? tas_pkg::APP_BOOT : tas_pkg::APP_MEAS);
			host.reg_write(tas_pkg::REG_REQ_APP, code);
			if (exp_app(code, 8'h00) != 8'h00) rev = (code == 8'h80) ? tas_pkg::BOOT_MAJOR_REV : tas_pkg::MEAS_MAJOR_REV;
			app = exp_app(code, app);
			repeat (6) @(negedge clk_sys);
			host.poll_app(app, d);
			chk_val("running app", {8'h0, app}, {8'h0, d});
			host.reg_read(tas_pkg::REG_REQ_APP, d);
			chk_val("request stored", {8'h0, code}, {8'h0, d});
			host.reg_read(tas_pkg::REG_MAJOR_REV, d);
			chk_val("revision", {8'h0, rev}, {8'h0, d});
		end
		host.reg_write(tas_pkg::REG_RUNNING_APP, ~app);
		host.reg_read(tas_pkg::REG_RUNNING_APP, d);
		chk_val("running after write", {8'h0, app}, {8'h0, d});
		code = 8'(rnd());
		host.reg_write(tas_pkg::REG_MAJOR_REV, code);
		host.reg_read(tas_pkg::REG_MAJOR_REV, d);
		chk_val("revision write", {8'h0, code}, {8'h0, d});
		host.command(8'h05, 32'ha3000384, acc);
		chk_bit("unknown command", 1'b0, acc);
		$display("Test application select done");
		run_meas(tas_pkg::CMD_MEAS_A, 16'h0384, 8'h00, 8'ha3, 20, 1'b0, 16'h0);
		run_meas(tas_pkg::CMD_MEAS_B, 16'h0002, 8'(rnd()), 8'(rnd()), 6, 1'b1, 16'h0);
		run_meas(tas_pkg::CMD_MEAS_A, 16'h0003, 8'h00, 8'h00, 0, 1'b0, 16'h0);
		chk_bit("no object", 1'b1, result_mm > tas_pkg::NO_OBJECT_LIMIT_MM);
		run_meas(tas_pkg::CMD_MEAS_B, 16'h0001, 8'h00, 8'h00, 2, 1'b0, 16'd199);
		run_meas(tas_pkg::CMD_MEAS_B, 16'h0001, 8'h00, 8'h00, 2, 1'b1, 16'd200);
		finish_test();
	end
endmodule : tb
